// [rbm_map.svh]
// Constants of the receive buffer ring manager
`ifndef RBM_MAP_SVH
`define RBM_MAP_SVH

`define RBM_HDR_BYTES     8'h04
`define RBM_PAGE_LAST_OFF 8'hff
`define RBM_MAX_LINKED    3'h6
`define RBM_CMD_STP_BIT   0
`define RBM_CMD_STA_BIT   1
`define RBM_CMD_TXP_BIT   2
`define RBM_CMD_PS_LSB    6
`define RBM_CMD_RST_VAL   8'h21
`define RBM_ISR_PRX_BIT   0
`define RBM_ISR_RXE_BIT   2
`define RBM_ISR_OVW_BIT   4
`define RBM_ISR_RST_VAL   8'h00
`define RBM_TCR_LB_LSB    1
`define RBM_TCR_LB_MSB    2

`endif

// [rbm_pkg.sv]
// Types of the receive buffer ring manager
package rbm_pkg;

    typedef enum logic [3:0] {
        RBM_IDLE = 4'h1,
        RBM_RECV = 4'h2,
        RBM_DROP = 4'h4,
        RBM_HDR  = 4'h8
    } rbm_state_e;

    typedef logic [7:0] rbm_page_t;

endpackage : rbm_pkg

// [rbm_link_if.sv]
// Page link check signals between ring manager and link calculator
`timescale 1ns/1ns
interface rbm_link_if;
    logic [7:0] page;
    logic [7:0] start_page;
    logic [7:0] stop_page;
    logic [7:0] read_page;
    logic [7:0] next_page;
    logic       hits_read;

    modport calc (
        input  page, start_page, stop_page, read_page,
        output next_page, hits_read
    );
    modport user (
        output page, start_page, stop_page, read_page,
        input  next_page, hits_read
    );
endinterface : rbm_link_if

// [rbm_page_link.sv]
// Next ring page with wrap, and read pointer collision check
`timescale 1ns/1ns
module rbm_page_link (
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    rbm_link_if.calc  lnk
);

    function automatic logic [7:0] rbm_wrap_next(
        input logic [7:0] pg,
        input logic [7:0] start_pg,
        input logic [7:0] stop_pg
    );
        logic [7:0] inc;
        inc = pg + 8'h01;
        // Compared as whole page numbers, never full addresses
        rbm_wrap_next = (inc == stop_pg) ? start_pg : inc; // R3 R25
    endfunction : rbm_wrap_next

    always_comb begin
        lnk.next_page = rbm_wrap_next(lnk.page, lnk.start_page,
                                      lnk.stop_page);
        lnk.hits_read = (lnk.next_page == lnk.read_page); // R4
    end

    AST_WRAP_TO_START: assert property ( // R3
        @(posedge sys_clk_i) disable iff (srst_i)
        (lnk.page + 8'h01 == lnk.stop_page) |->
            (lnk.next_page == lnk.start_page))
        else $error("next page did not wrap to ring start");

endmodule : rbm_page_link

// [rbm_tally.sv]
// Missed frame tally counter, frozen while the device is stopped
`timescale 1ns/1ns
module rbm_tally #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    input  wire logic             miss_i,
    input  wire logic             stopped_i,
    output logic      [WIDTH-1:0] count_o
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } rbm_tally_s;

    rbm_tally_s st_q;
    rbm_tally_s st_d;

    always_comb begin
        st_d = st_q;
        if (miss_i && !stopped_i) begin // R15
            st_d.cnt = st_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_o = st_q.cnt;

    AST_TALLY_FROZEN: assert property ( // R15
        @(posedge sys_clk_i) disable iff (srst_i)
        stopped_i |=> $stable(count_o))
        else $error("missed tally counted while stopped");

endmodule : rbm_tally

// [rbm_ring_manager.sv]
// Receive buffer ring manager: page linking, header write, recovery
//
// Notes on behaviour
// R1: Full page continues into the following page
// R2: Frames use consecutive pages, six at most; the code links pages with no count limit
// R3: Next page equal stop page wraps to start
// R4: Next page equal read pointer aborts frame
// R5: Link only when neither comparison matches
// R6: Overflow abort keeps earlier frames intact
// R7: Overflow sets overwrite warning; host recovers fully
// R8: Stop command ends after frame in progress
// R9: Host waits 1.6 ms, clears remote counts
// R10: Host resend flag from saved pending bit
// R11: Host selects loopback mode 1 or 2
// R12: Start command; loopback keeps receive DMA idle
// R13: Host clears warning, then leaves loopback
// R14: Resend command transmits pending frame again
// R15: Missed tally frozen while stopped
// R16: Command selects register page 0 or 1
// R17: Writing ones clears status flags
// R18: Host re-enable sequence order
// R19: Accepted frame header written at write pointer
// R20: Write pointer takes precomputed next page
// R21: Bad frames reclaimed unless configured to accept
// R22: Check sequence stored right after data
// R23: Frame data starts four bytes into page
// R24: Host inits pointers to start, never zero
// R25: Comparisons on the 8-bit page number
// R26: Header next pointer follows last used page
`timescale 1ns/1ns
`include "rbm_map.svh"
module rbm_ring_manager #(
    parameter int TALLY_W = 8
) (
    input  wire logic               sys_clk_i,
    input  wire logic               srst_i,
    input  wire logic [7:0]         ring_start_page_i,
    input  wire logic [7:0]         ring_stop_page_i,
    input  wire logic [7:0]         host_read_pointer_i,
    input  wire logic               wr_ptr_load_i,
    input  wire logic [7:0]         wr_ptr_data_i,
    input  wire logic               cmd_wr_i,
    input  wire logic [7:0]         cmd_data_i,
    input  wire logic               status_wr_i,
    input  wire logic [7:0]         status_data_i,
    input  wire logic [7:0]         tx_config_i,
    input  wire logic               accept_bad_i,
    input  wire logic               rx_start_i,
    input  wire logic               rx_byte_valid_i,
    input  wire logic [7:0]         rx_byte_i,
    input  wire logic               rx_end_i,
    input  wire logic               rx_good_i,
    input  wire logic [7:0]         rx_status_i,
    output logic                    mem_wr_o,
    output logic [15:0]             mem_addr_o,
    output logic [7:0]              mem_data_o,
    output logic [7:0]              rx_write_pointer_o,
    output logic [7:0]              interrupt_status_o,
    output logic                    overwrite_warning_flag_o,
    output logic                    stopped_o,
    output logic [1:0]              reg_page_o,
    output logic                    tx_start_o,
    output logic [TALLY_W-1:0]      missed_count_o
);

    typedef struct packed {
        rbm_pkg::rbm_state_e st;
        rbm_pkg::rbm_page_t  rx_write_pointer;
        rbm_pkg::rbm_page_t  page;
        logic [7:0]          off;
        logic [15:0]         cnt;
        logic [1:0]          hidx;
        rbm_pkg::rbm_page_t  nxtf;
        logic [7:0]          rstat;
        logic                stop_pend;
        logic                stopped;
        logic [7:0]          interrupt_status;
        logic [1:0]          regpage;
        logic                mem_wr;
        logic [15:0]         mem_addr;
        logic [7:0]          mem_data;
        logic                tx_start;
        logic                miss;
    } rbm_top_s;

    rbm_top_s q;
    rbm_top_s d;

    rbm_link_if lnk ();

    rbm_page_link u_link (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .lnk       (lnk)
    );

    rbm_tally #(
        .WIDTH (TALLY_W)
    ) u_tally (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .miss_i    (q.miss),
        .stopped_i (q.stopped),
        .count_o   (missed_count_o)
    );

    logic loopback;
    logic rx_active;
    logic accept_end;
    logic clr_ovw;

    always_comb begin
        lnk.page       = q.page;
        lnk.start_page = ring_start_page_i;
        lnk.stop_page  = ring_stop_page_i;
        lnk.read_page  = host_read_pointer_i;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    ////////////////////////////////////////////////////////////////////

    always_comb begin
        // Loopback modes keep the local receive DMA idle
        loopback   = |tx_config_i[`RBM_TCR_LB_MSB:`RBM_TCR_LB_LSB]; // R12
        rx_active  = !q.stopped && !loopback;
        accept_end = rx_end_i && (rx_good_i || accept_bad_i); // R21
        clr_ovw    = status_wr_i && status_data_i[`RBM_ISR_OVW_BIT];
        d          = q;
        d.mem_wr   = 1'b0;
        d.tx_start = 1'b0;
        d.miss     = 1'b0;

        // Write-one-to-clear; hardware sets below win the same cycle
        if (status_wr_i) begin
            d.interrupt_status = q.interrupt_status & ~status_data_i; // R17
        end

        if (cmd_wr_i) begin
            d.regpage = cmd_data_i[`RBM_CMD_PS_LSB+1:`RBM_CMD_PS_LSB]; // R16
            if (cmd_data_i[`RBM_CMD_STP_BIT]) begin
                d.stop_pend = 1'b1; // R8
            end else if (cmd_data_i[`RBM_CMD_STA_BIT]) begin
                d.stop_pend = 1'b0; // R12
                d.stopped   = 1'b0;
                d.tx_start  = cmd_data_i[`RBM_CMD_TXP_BIT]; // R14
            end
        end

        if (wr_ptr_load_i) begin
            d.rx_write_pointer = wr_ptr_data_i;
        end

        case (q.st)
            rbm_pkg::RBM_IDLE: begin
                // Stop only takes effect between frames
                if (q.stop_pend && !(cmd_wr_i &&
                        cmd_data_i[`RBM_CMD_STA_BIT] &&
                        !cmd_data_i[`RBM_CMD_STP_BIT])) begin
                    d.stopped   = 1'b1; // R8
                    d.stop_pend = 1'b0;
                end else if (rx_start_i && rx_active) begin
                    d.st   = rbm_pkg::RBM_RECV;
                    d.page = q.rx_write_pointer;
                    d.off  = `RBM_HDR_BYTES; // R23
                    d.cnt  = {8'h00, `RBM_HDR_BYTES};
                end
            end
            rbm_pkg::RBM_RECV: begin
                if (rx_end_i) begin
                    if (accept_end) begin
                        // Unused tail of last page is abandoned
                        d.nxtf  = (q.off == 8'h00) ? q.page
                                                   : lnk.next_page; // R26 R20
                        d.rstat = rx_status_i;
                        d.hidx  = 2'h0;
                        d.st    = rbm_pkg::RBM_HDR;
                    end else begin
                        // Pages reclaimed: write pointer left alone
                        d.st = rbm_pkg::RBM_IDLE; // R21
                        d.interrupt_status[`RBM_ISR_RXE_BIT] = 1'b1;
                    end
                end else if (rx_byte_valid_i) begin
                    // Check sequence bytes arrive in the same stream
                    d.mem_wr   = 1'b1; // R22
                    d.mem_addr = {q.page, q.off};
                    d.mem_data = rx_byte_i;
                    d.off      = q.off + 8'h01;
                    d.cnt      = q.cnt + 16'h0001;
                    if (q.off == `RBM_PAGE_LAST_OFF) begin
                        if (lnk.hits_read) begin
                            // Never enter the unread page
                            d.st   = rbm_pkg::RBM_DROP; // R4 R6
                            d.miss = 1'b1;
                            d.interrupt_status[`RBM_ISR_OVW_BIT] = 1'b1; // R7
                        end else begin
                            d.page = lnk.next_page; // R1 R2 R3 R5
                        end
                    end
                end
            end
            rbm_pkg::RBM_DROP: begin
                if (rx_end_i) begin
                    d.st = rbm_pkg::RBM_IDLE;
                end
            end
            rbm_pkg::RBM_HDR: begin
                d.mem_wr   = 1'b1; // R19
                d.mem_addr = {q.rx_write_pointer, 6'h00, q.hidx};
                case (q.hidx)
                    2'h0:    d.mem_data = q.rstat;
                    2'h1:    d.mem_data = q.nxtf;
                    2'h2:    d.mem_data = q.cnt[7:0];
                    default: d.mem_data = q.cnt[15:8];
                endcase
                d.hidx = q.hidx + 2'h1;
                if (q.hidx == 2'h3) begin
                    d.rx_write_pointer = q.nxtf; // R20
                    d.st   = rbm_pkg::RBM_IDLE;
                    d.interrupt_status[`RBM_ISR_PRX_BIT] = 1'b1;
                end
            end
            default: d.st = rbm_pkg::RBM_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    ////////////////////////////////////////////////////////////////////

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            q         <= '0;
            q.st      <= rbm_pkg::RBM_IDLE;
            q.stopped <= 1'b1;
            q.interrupt_status     <= `RBM_ISR_RST_VAL;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        mem_wr_o                 = q.mem_wr;
        mem_addr_o               = q.mem_addr;
        mem_data_o               = q.mem_data;
        rx_write_pointer_o       = q.rx_write_pointer;
        interrupt_status_o       = q.interrupt_status;
        overwrite_warning_flag_o = q.interrupt_status[`RBM_ISR_OVW_BIT];
        stopped_o                = q.stopped;
        reg_page_o               = q.regpage;
        tx_start_o               = q.tx_start;
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////

    logic page_end_wr;
    assign page_end_wr = (q.st == rbm_pkg::RBM_RECV) && !rx_end_i &&
                         rx_byte_valid_i && (q.off == `RBM_PAGE_LAST_OFF);

    sequence s_hdr_writes(logic [7:0] pg);
        (mem_wr_o && mem_addr_o == {pg, 8'h00}) ##1
        (mem_wr_o && mem_addr_o == {pg, 8'h01}) ##1
        (mem_wr_o && mem_addr_o == {pg, 8'h02}) ##1
        // Write pointer moves on the edge of the last header write
        (mem_wr_o && mem_addr_o == {$past(pg), 8'h03});
    endsequence

    AST_LINK_NEXT: assert property ( // R5
        @(posedge sys_clk_i) disable iff (srst_i)
        (page_end_wr && !lnk.hits_read) |=>
            (q.page == $past(lnk.next_page) && q.off == 8'h00))
        else $error("page link did not move into next page");

    AST_ABORT_AT_READ: assert property ( // R4
        @(posedge sys_clk_i) disable iff (srst_i)
        (page_end_wr && lnk.hits_read) |=>
            (q.st == rbm_pkg::RBM_DROP && overwrite_warning_flag_o))
        else $error("collision with read pointer not aborted");

    AST_NO_WRITE_DROP: assert property ( // R6
        @(posedge sys_clk_i) disable iff (srst_i)
        (q.st == rbm_pkg::RBM_DROP) |=> !mem_wr_o)
        else $error("memory written after overflow abort");

    AST_START_OFFSET: assert property ( // R23
        @(posedge sys_clk_i) disable iff (srst_i)
        (q.st == rbm_pkg::RBM_IDLE && rx_start_i && rx_active &&
         !q.stop_pend && !wr_ptr_load_i) |=>
            (q.off == `RBM_HDR_BYTES && q.page == $past(q.rx_write_pointer)))
        else $error("frame did not start four bytes into page");

    AST_HDR_SEQ: assert property ( // R19
        @(posedge sys_clk_i) disable iff (srst_i)
        (q.st == rbm_pkg::RBM_RECV && accept_end && !wr_ptr_load_i) |=>
            ##1 s_hdr_writes(q.rx_write_pointer))
        else $error("frame header not written at write pointer");

    AST_RX_WRITE_POINTER_UPDATE: assert property ( // R20
        @(posedge sys_clk_i) disable iff (srst_i)
        (q.st == rbm_pkg::RBM_HDR && q.hidx == 2'h3 && !wr_ptr_load_i)
            |=> (rx_write_pointer_o == $past(q.nxtf)))
        else $error("write pointer not loaded with next page");

    AST_REJECT_RECLAIM: assert property ( // R21
        @(posedge sys_clk_i) disable iff (srst_i)
        (q.st == rbm_pkg::RBM_RECV && rx_end_i && !accept_end &&
         !wr_ptr_load_i) |=>
            (q.st == rbm_pkg::RBM_IDLE && $stable(rx_write_pointer_o))
            ##1 !mem_wr_o)
        else $error("rejected frame pages not reclaimed");

    AST_OVW_SET_WINS: assert property ( // R17
        @(posedge sys_clk_i) disable iff (srst_i)
        (page_end_wr && lnk.hits_read && clr_ovw) |=>
            overwrite_warning_flag_o)
        else $error("overflow lost against same cycle clear");

    AST_STOP_AFTER_FRAME: assert property ( // R8
        @(posedge sys_clk_i) disable iff (srst_i)
        (q.st == rbm_pkg::RBM_RECV && !q.stopped) |=> !stopped_o)
        else $error("device stopped in the middle of a frame");

    AST_LOOPBACK_IDLE: assert property ( // R12
        @(posedge sys_clk_i) disable iff (srst_i)
        (q.st == rbm_pkg::RBM_IDLE && loopback) |=>
            (q.st == rbm_pkg::RBM_IDLE))
        else $error("receive DMA left idle in loopback");

    AST_RESEND_PULSE: assert property ( // R14
        @(posedge sys_clk_i) disable iff (srst_i)
        (cmd_wr_i && cmd_data_i[`RBM_CMD_STA_BIT] &&
         !cmd_data_i[`RBM_CMD_STP_BIT] && cmd_data_i[`RBM_CMD_TXP_BIT])
            |=> tx_start_o)
        else $error("resend command gave no transmit start");

    AST_PAGE_SELECT: assert property ( // R16
        @(posedge sys_clk_i) disable iff (srst_i)
        cmd_wr_i |=> (reg_page_o ==
            $past(cmd_data_i[`RBM_CMD_PS_LSB+1:`RBM_CMD_PS_LSB])))
        else $error("register page not taken from command");

endmodule : rbm_ring_manager

// [rbm_buf_mem_model.sv]
// Local buffer memory model seen by the receive DMA
`timescale 1ns/1ns
module rbm_buf_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic        mem_wr_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [7:0]  mem_data_i,
    input  wire logic [7:0]  host_read_pointer_i
);
    logic [7:0] mem [logic [15:0]];
    int         n_wr = 0;
    int         n_guard = 0;

    always @(posedge sys_clk_i) begin
        if (mem_wr_i === 1'b1) begin
            mem[mem_addr_i] = mem_data_i;
            n_wr++;
            // Page still owned by the host must stay untouched
            if (mem_addr_i[15:8] == host_read_pointer_i) begin
                n_guard++;
            end
        end
    end
endmodule : rbm_buf_mem_model

// [rx_buffer_ring_manager_tb.sv]
// Self-checking bench of the receive buffer ring manager
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    n_fail++; $display("unexpected t=%0t got %h exp %h", $time, got, exp); \
    end end
module rx_buffer_ring_manager_tb;
    logic        sys_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [7:0]  ring_start_page_i = 8'h40;
    logic [7:0]  ring_stop_page_i = 8'h48;
    logic [7:0]  host_read_pointer_i = 8'h47;
    logic        wr_ptr_load_i = 1'b0;
    logic [7:0]  wr_ptr_data_i = 8'h00;
    logic        cmd_wr_i = 1'b0;
    logic [7:0]  cmd_data_i = 8'h00;
    logic        status_wr_i = 1'b0;
    logic [7:0]  status_data_i = 8'h00;
    logic [7:0]  tx_config_i = 8'h00;
    logic        accept_bad_i = 1'b0;
    logic        rx_start_i = 1'b0;
    logic        rx_byte_valid_i = 1'b0;
    logic [7:0]  rx_byte_i = 8'h00;
    logic        rx_end_i = 1'b0;
    logic        rx_good_i = 1'b0;
    logic [7:0]  rx_status_i = 8'h21;
    logic        mem_wr_o;
    logic [15:0] mem_addr_o;
    logic [7:0]  mem_data_o;
    logic [7:0]  rx_write_pointer_o;
    logic [7:0]  interrupt_status_o;
    logic        overwrite_warning_flag_o;
    logic        stopped_o;
    logic [1:0]  reg_page_o;
    logic        tx_start_o;
    logic [7:0]  missed_count_o;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          pulses;

    rbm_ring_manager #(.TALLY_W(8)) rbm_ring_manager_inst (.*);
    rbm_buf_mem_model rbm_buf_mem_model_inst (
        .sys_clk_i          (sys_clk_i),
        .mem_wr_i           (mem_wr_o),
        .mem_addr_i         (mem_addr_o),
        .mem_data_i         (mem_data_o),
        .host_read_pointer_i(host_read_pointer_i)
    );

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : step

    task automatic cmd(input logic [7:0] v);
        cmd_wr_i = 1'b1;
        cmd_data_i = v;
        step(1);
        cmd_wr_i = 1'b0;
        step(2);
    endtask : cmd

    task automatic clr(input logic [7:0] v);
        status_wr_i = 1'b1;
        status_data_i = v;
        step(1);
        status_wr_i = 1'b0;
        step(1);
    endtask : clr

    task automatic load_wp(input logic [7:0] v);
        wr_ptr_load_i = 1'b1;
        wr_ptr_data_i = v;
        step(1);
        wr_ptr_load_i = 1'b0;
        step(1);
    endtask : load_wp

    function automatic logic [7:0] nxt(input logic [7:0] pg);
        logic [7:0] q;
        q = pg + 8'h01;
        return (q == ring_stop_page_i) ? ring_start_page_i : q;
    endfunction : nxt

    ////////////////////////////////////////////////////////////////////
    // One frame of n bytes (data plus check bytes); live = device may take it
    task automatic frame(input int n, input logic good, input logic live);
        logic [7:0]  p;
        logic [7:0]  o;
        logic [7:0]  wp;
        logic [7:0]  tally;
        logic        drop;
        logic        acc;
        logic        rej;
        logic [15:0] cnt;
        int          w0;
        int          i;
        logic [15:0] qa[$];
        logic [7:0]  qd[$];
        clr(8'hff);
        `CHK(interrupt_status_o, 8'h00)
        wp = rx_write_pointer_o;
        p = wp;
        o = 8'h04;
        drop = 1'b0;
        tally = missed_count_o;
        w0 = rbm_buf_mem_model_inst.n_wr;
        rx_start_i = 1'b1;
        step(1);
        rx_start_i = 1'b0;
        for (i = 0; i < n; i++) begin
            if (live && o == 8'h00 && !drop) begin
                p = nxt(p);
                drop = (p == host_read_pointer_i);
            end
            if (live && !drop) begin
                qa.push_back({p, o});
                qd.push_back(i[7:0] ^ 8'h5a);
            end
            // Clear lands on the abort edge; the hardware set must win
            status_wr_i = live && !drop && o == 8'hff &&
                          nxt(p) == host_read_pointer_i;
            rx_byte_valid_i = 1'b1;
            rx_byte_i = i[7:0] ^ 8'h5a;
            o++;
            step(1);
        end
        rx_byte_valid_i = 1'b0;
        status_wr_i = 1'b0;
        rx_end_i = 1'b1;
        rx_good_i = good;
        step(1);
        rx_end_i = 1'b0;
        step(10);
        acc = live && !drop && (good || accept_bad_i);
        rej = live && !drop && !acc;
        cnt = 16'(n + 4);
        foreach (qa[k]) `CHK(rbm_buf_mem_model_inst.mem[qa[k]], qd[k])
        `CHK(rbm_buf_mem_model_inst.n_wr - w0, qa.size() + (acc ? 4 : 0))
        if (acc) begin
            `CHK(rbm_buf_mem_model_inst.mem[{wp, 8'h00}], rx_status_i)
            `CHK(rbm_buf_mem_model_inst.mem[{wp, 8'h01}], nxt(p))
            `CHK(rbm_buf_mem_model_inst.mem[{wp, 8'h02}], cnt[7:0])
            `CHK(rbm_buf_mem_model_inst.mem[{wp, 8'h03}], cnt[15:8])
        end
        `CHK(rx_write_pointer_o, acc ? nxt(p) : wp)
        `CHK(interrupt_status_o, {3'h0, drop, 1'b0, rej, 1'b0, acc})
        `CHK(overwrite_warning_flag_o, drop)
        `CHK(missed_count_o, tally + {7'h00, drop})
    endtask : frame

    ////////////////////////////////////////////////////////////////////
    initial begin
        step(16);
        srst_i = 1'b0;
        step(1);
        `CHK({stopped_o, reg_page_o, tx_start_o, mem_wr_o}, 5'h10)
        `CHK({interrupt_status_o, rx_write_pointer_o}, 16'h0000)
        `CHK(missed_count_o, 8'h00)
        load_wp(ring_start_page_i);
        frame(20, 1'b1, 1'b0);
        cmd(8'h61);
        `CHK(reg_page_o, 2'h1)
        cmd(8'h21);
        `CHK({stopped_o, reg_page_o}, 3'h4)
        cmd(8'h22);
        `CHK(stopped_o, 1'b0)
        for (int k = 1; k < 3; k++) begin
            tx_config_i = 8'(k * 2);
            frame(30, 1'b1, 1'b0);
        end
        tx_config_i = 8'h00;
        frame(60, 1'b1, 1'b1);
        // Exactly fills one page: next frame must start a fresh page
        frame(252, 1'b1, 1'b1);
        host_read_pointer_i = 8'h41;
        frame(1400, 1'b1, 1'b1);
        frame(300, 1'b1, 1'b1);
        cmd(8'h21);
        `CHK(stopped_o, 1'b1)
        // Host wait cut short: an idle device stops within two cycles
        step(20);
        tx_config_i = 8'h04;
        load_wp(8'h47);
        cmd(8'h22);
        host_read_pointer_i = 8'h43;
        clr(8'hff);
        `CHK(overwrite_warning_flag_o, 1'b0)
        tx_config_i = 8'h00;
        frame(300, 1'b1, 1'b1);
        frame(40, 1'b0, 1'b1);
        accept_bad_i = 1'b1;
        frame(40, 1'b0, 1'b1);
        accept_bad_i = 1'b0;
        cmd_wr_i = 1'b1;
        // Resend set: pending bit saved as one, no transmit status seen
        cmd_data_i = 8'h26;
        step(1);
        cmd_wr_i = 1'b0;
        pulses = 0;
        repeat (4) begin
            pulses += int'(tx_start_o === 1'b1);
            step(1);
        end
        `CHK(pulses, 1)
        cmd(8'h21);
        host_read_pointer_i = 8'h42;
        frame(600, 1'b1, 1'b0);
        `CHK(rbm_buf_mem_model_inst.n_guard, 0)
        tally_and_finish();
    end
endmodule : rx_buffer_ring_manager_tb
